/* dv/boot_mode_select_asserts.sv */
// Boot select checker.
// Assumes one clock.
`default_nettype none
module boot_mode_select_asserts
  import boot_pkg::*;
(
  // Watched ports
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic sw_reset,
  input wire logic bus_req,
  input wire logic boot_irq,
  input wire logic [23:0] fetch_addr,
  input wire logic boot_done,
  input wire logic [2:0] boot_mode,
  input wire logic mode_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  rom_vec_a: assert property (fetch_addr == 24'hFF0000) else $error("vector");
  irq_once_a: assert property (boot_irq |=> !boot_irq) else $error("irq");
  irq_run_a: assert property (boot_irq |=> boot_done) else $error("run");
  run_cause_a: assert property ($rose(boot_done) |-> $past(boot_irq))
    else $error("early");
  bus_gate_a: assert property (boot_irq |-> !$past(bus_req)) else $error("bus");
  mode_ok_a: assert property (mode_valid == (boot_mode inside {[3'h1:3'h5]}))
    else $error("valid");
  mode_keep_a: assert property ($past(boot_done) |-> $stable(boot_mode))
    else $error("mode");
  sw_boot_a: assert property (boot_done && sw_reset && !bus_req |-> ##[1:6] boot_irq)
    else $error("sw");
  freeze_hold_a: assert property (!clk_en |=> $stable(boot_irq) && $stable(boot_done)
    && $stable(boot_mode)) else $error("freeze");
  cover property (boot_irq && !mode_valid);
  cover property (boot_irq && boot_mode == 3'h5);
  cover property (boot_done && sw_reset);
  cover property (!clk_en && !bus_req && !boot_done);
endmodule
bind boot_mode_select boot_mode_select_asserts i_chk (.sys_clk, .nrst, .clk_en, .sw_reset, .bus_req,
  .boot_irq, .fetch_addr, .boot_done, .boot_mode, .mode_valid);
`default_nettype wire

/* dv/strap_model.sv */
// Strap model driving the boot pins.
// Assumes one clock shared with the block.
`default_nettype none
module strap_model (
  // Clock, status and pins
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic boot_done,
  input wire logic [2:0] code,
  output logic [2:0] pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Straps move only in reset or after boot, never while sampled.
  always @(posedge sys_clk) if (!nrst || boot_done) pins <= code;
endmodule
`default_nettype wire

/* dv/tb.sv */
// Bench for the boot select block.
// Assumes the strap model and checker.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, nrst = 1'b0, sw_reset = 1'b0, bus_req = 1'b0, boot_irq, boot_done;
  logic mode_valid, load_emi8, exec_ext8, exec_ext16, spi_boot, spi_large;
  logic clk_en = 1'b1;
  logic [2:0] code = 3'h0, pins;
  logic [23:0] fetch_addr;
  boot_pkg::boot_mode_t boot_mode;
  int fails = 0, compares = 0, n;
  initial forever #2.5 sys_clk = ~sys_clk;
  strap_model i_strap_model (.sys_clk, .nrst, .boot_done, .code, .pins);
  boot_mode_select i_boot_mode_select (.sys_clk, .nrst, .clk_en, .sw_reset, .bus_req,
    .boot_sel_pin_hi(pins[2]), .boot_sel_pin_mid(pins[1]), .boot_sel_pin_lo(pins[0]),
    .boot_irq, .fetch_addr, .boot_done, .boot_mode, .mode_valid, .load_emi8, .exec_ext8,
    .exec_ext16, .spi_boot, .spi_large);
  task check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wait_irq();
    for (n = 0; boot_irq !== 1'b1 && n < 30; n++) @(posedge sys_clk) #1;
    check(24'(n < 30), 24'h1);
    if (n == 30) complete_run();
  endtask
  task hw_boot(input logic [2:0] c, input logic b);
    @(posedge sys_clk);
    {code, bus_req, nrst} <= {c, b, 1'b0};
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  task boot_codes();
    for (int c = 0; c < 8; c++) begin
      hw_boot(3'(c), 1'b0);
      wait_irq();
      check(24'(n), 24'h6);
      check(24'(boot_mode), (c > 0 && c < 6) ? 24'(c) : 24'h0);
      check(fetch_addr, 24'hFF0000);
      check({mode_valid, load_emi8, exec_ext8, exec_ext16, spi_boot, spi_large},
        {c > 0 && c < 6, c == 1, c == 2, c == 3, c == 4 || c == 5, c == 5});
    end
  endtask
  task bus_wait();
    hw_boot(3'h3, 1'b1);
    repeat (20) @(posedge sys_clk);
    #1 check(boot_done, 1'b0);
    @(posedge sys_clk) {clk_en, bus_req} <= 2'b00;
    repeat (5) @(posedge sys_clk);
    #1 check({boot_irq, boot_done}, 2'b00);
    @(posedge sys_clk) clk_en <= 1'b1;
    wait_irq();
    check(24'(n), 24'h1);
  endtask
  task sw_path();
    @(posedge sys_clk);
    {code, sw_reset} <= {3'h4, 1'b1};
    @(posedge sys_clk) sw_reset <= 1'b0;
    wait_irq();
    check(24'(n), 24'h2);
    check(24'(boot_mode), 24'h3);
  endtask
  initial begin
    boot_codes();
    bus_wait();
    sw_path();
    complete_run();
  end
endmodule
`default_nettype wire

/* verilog/boot_defs.svh */
// Constants for the boot mode selection block.
// Assumes inclusion by bare name from design files only.
`ifndef BOOT_DEFS_SVH
`define BOOT_DEFS_SVH
`define BOOT_ROM_VECTOR 24'hFF0000
`define BOOT_CODE_W 3
`define BOOT_CODE_EMI_LOAD8 3'h1
`define BOOT_CODE_EXEC8 3'h2
`define BOOT_CODE_EXEC16 3'h3
`define BOOT_CODE_SPI_SMALL 3'h4
`define BOOT_CODE_SPI_LARGE 3'h5
`define BOOT_SAMPLE_CYCLES 4'h4
`endif

/* verilog/boot_mode_select.sv */
// Boot mode selection and boot entry sequencing.
// Assumes pins are asynchronous straps and the core acts on boot_irq.
`include "boot_defs.svh"
`default_nettype none
// Functional notes
// - Three strap pins give eight codes of which five are valid; 000, 110, 111 are flagged.
// - The boot interrupt is nonmaskable and vectors to the on-chip ROM at 0xFF0000.
// - The boot interrupt is raised after both hardware reset and software reset.
// - After any reset the fetch address is the boot ROM regardless of the pins.
// - The pins are captured at hardware reset and must be stable then.
// - Code 001 selects loading from 8-bit memory over the external memory port.
// - Code 010 selects direct execution from 8-bit external memory.
// - Code 011 selects direct execution from 16-bit external memory.
// - Code 100 selects SPI boot from at most 4K bits and 101 from more than 4K bits.
// - On reset release the jump to the boot ROM waits while a bus request is pending.
module boot_mode_select
  import boot_pkg::*;
(
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Boot strap pins
  input wire logic boot_sel_pin_hi,
  input wire logic boot_sel_pin_mid,
  input wire logic boot_sel_pin_lo,
  // System controls
  input wire logic sw_reset,
  input wire logic bus_req,
  // Boot entry to the core
  output logic boot_irq,
  output logic [23:0] fetch_addr,
  output logic boot_done,
  // Latched mode for the boot ROM code
  output boot_pkg::boot_mode_t boot_mode,
  output logic mode_valid,
  output logic load_emi8,
  output logic exec_ext8,
  output logic exec_ext16,
  output logic spi_boot,
  output logic spi_large
);
  import boot_pkg::*;

  boot_pin_if pin_bus ();
  boot_state_t state_ff;
  boot_state_t nxt_state;
  logic [3:0] sample_cnt_ff;
  logic [2:0] code_ff;
  logic sw_req_ff;
  // Next values of the decoded mode outputs.
  logic nxt_mode_valid;
  logic nxt_load_emi8;
  logic nxt_exec_ext8;
  logic nxt_exec_ext16;
  logic nxt_spi_boot;
  logic nxt_spi_large;
  boot_mode_t nxt_boot_mode;

  function automatic logic code_is_valid(input logic [2:0] c);
    code_is_valid = (c >= `BOOT_CODE_EMI_LOAD8) && (c <= `BOOT_CODE_SPI_LARGE);
  endfunction

  // Straps are asynchronous, so they pass the three-stage synchroniser first.
  boot_pin_sync u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pins({boot_sel_pin_hi, boot_sel_pin_mid, boot_sel_pin_lo}),
    .out(pin_bus)
  );

  // A software reset request is held until the sequencer restarts.
  // A request in the same cycle as the clear wins, so none is lost.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sw_req_ff <= 1'b0;
    end else if (clk_en) begin
      if (sw_reset) begin
        sw_req_ff <= 1'b1;
      end else if (state_ff == ST_WAIT_BUS) begin
        sw_req_ff <= 1'b0;
      end
    end
  end

  // Straps are sampled once, then the sequencer waits for the bus, vectors and runs.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SAMPLE: begin
        if (sample_cnt_ff == `BOOT_SAMPLE_CYCLES && pin_bus.stable) begin
          nxt_state = ST_WAIT_BUS;
        end
      end
      ST_WAIT_BUS: begin
        if (!bus_req) begin
          nxt_state = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (sw_req_ff) begin
          nxt_state = ST_WAIT_BUS;
        end
      end
      default: begin
        nxt_state = ST_SAMPLE;
      end
    endcase
  end

  // State only moves while the clock enable is high.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_SAMPLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Counts cycles after hardware reset so the synchroniser has filled.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sample_cnt_ff <= 4'h0;
    end else if (clk_en && state_ff == ST_SAMPLE && sample_cnt_ff != `BOOT_SAMPLE_CYCLES) begin
      sample_cnt_ff <= sample_cnt_ff + 4'h1;
    end
  end

  // The code is captured only after hardware reset and kept across software reset.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      code_ff <= 3'h0;
    end else if (clk_en && state_ff == ST_SAMPLE && nxt_state == ST_WAIT_BUS) begin
      code_ff <= pin_bus.code;
    end
  end

  // The boot interrupt has no mask input; only reset, clk_en low, the strap sampling wait for stable pins or a pending bus_req can hold it off.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      boot_irq <= 1'b0;
    end else if (clk_en) begin
      boot_irq <= (nxt_state == ST_VECTOR);
    end
  end

  // Every entry into the boot sequence points the fetch at the ROM vector.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_addr <= `BOOT_ROM_VECTOR;
    end else if (clk_en && (nxt_state == ST_VECTOR || nxt_state == ST_WAIT_BUS)) begin
      fetch_addr <= `BOOT_ROM_VECTOR;
    end
  end

  // The run state tells the core that the boot ROM has taken over.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      boot_done <= 1'b0;
    end else if (clk_en) begin
      boot_done <= (nxt_state == ST_RUN);
    end
  end

  // Reserved codes decode to no load path and a reserved mode.
  always_comb begin
    nxt_mode_valid = code_is_valid(code_ff);
    nxt_boot_mode = nxt_mode_valid ? boot_mode_t'(code_ff) : MODE_RESERVED;
    nxt_load_emi8 = 1'b0;
    nxt_exec_ext8 = 1'b0;
    nxt_exec_ext16 = 1'b0;
    nxt_spi_boot = 1'b0;
    nxt_spi_large = 1'b0;
    case (code_ff)
      `BOOT_CODE_EMI_LOAD8: begin
        nxt_load_emi8 = 1'b1;
      end
      `BOOT_CODE_EXEC8: begin
        nxt_exec_ext8 = 1'b1;
      end
      `BOOT_CODE_EXEC16: begin
        nxt_exec_ext16 = 1'b1;
      end
      `BOOT_CODE_SPI_SMALL: begin
        nxt_spi_boot = 1'b1;
      end
      `BOOT_CODE_SPI_LARGE: begin
        nxt_spi_boot = 1'b1;
        nxt_spi_large = 1'b1;
      end
      default: begin
        // Reserved codes still boot from the ROM, with no load path chosen.
        nxt_spi_large = 1'b0;
      end
    endcase
  end

  // Decoded mode outputs for the boot code.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      boot_mode <= MODE_RESERVED;
      mode_valid <= 1'b0;
      load_emi8 <= 1'b0;
      exec_ext8 <= 1'b0;
      exec_ext16 <= 1'b0;
      spi_boot <= 1'b0;
      spi_large <= 1'b0;
    end else if (clk_en) begin
      mode_valid <= nxt_mode_valid;
      boot_mode <= nxt_boot_mode;
      load_emi8 <= nxt_load_emi8;
      exec_ext8 <= nxt_exec_ext8;
      exec_ext16 <= nxt_exec_ext16;
      spi_boot <= nxt_spi_boot;
      spi_large <= nxt_spi_large;
    end
  end
endmodule
`default_nettype wire

/* verilog/boot_pin_if.sv */
// Interface carrying the synchronised boot pins between modules.
// Assumes a single clock domain.
`default_nettype none
interface boot_pin_if;
  logic [2:0] code;
  logic stable;
  modport src (output code, output stable);
  modport dst (input code, input stable);
endinterface
`default_nettype wire

/* verilog/boot_pin_sync.sv */
// Three-stage synchroniser for the boot strap pins.
// Assumes asynchronous pins and sys_clk domain.
`default_nettype none
module boot_pin_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Raw pins
  input wire logic [2:0] pins,
  // Synchronised code
  boot_pin_if.src out
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      s3_ff <= 3'h0;
    end else if (clk_en) begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change counts once the last two stages agree.
  assign out.code = s3_ff;
  assign out.stable = (s2_ff == s3_ff);
endmodule
`default_nettype wire

/* verilog/boot_pkg.sv */
// Types shared by the boot mode selection block.
// Assumes boot_defs.svh is on the include path.
`default_nettype none
package boot_pkg;
  typedef enum logic [2:0] {
    MODE_RESERVED = 3'h0,
    MODE_EMI_LOAD8 = 3'h1,
    MODE_EXEC8 = 3'h2,
    MODE_EXEC16 = 3'h3,
    MODE_SPI_SMALL = 3'h4,
    MODE_SPI_LARGE = 3'h5
  } boot_mode_t;
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'h0,
    ST_WAIT_BUS = 2'h1,
    ST_VECTOR = 2'h2,
    ST_RUN = 2'h3
  } boot_state_t;
endpackage
`default_nettype wire
